// ==== include/boot_pkg.sv ====
// shared constants and carrier types for the reset release and boot start block
package boot_pkg;

  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned STRAP_W        = 4;
  localparam int unsigned CLOCK_MHZ      = 100;
  localparam int unsigned PLL_LOCK_CYC   = 10000;
  localparam int unsigned CACHE_INIT_CYC = 1028;
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned PHASE_CYC      = 2;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CAPTURE,
    ST_RUN
  } boot_state_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [STRAP_W-1:0] out;
    logic [STRAP_W-1:0] oe;
  } strap_drive_s;

  typedef struct packed {
    logic               boot_fetch_start;
    logic               boot_fetch_active;
    logic [STRAP_W-1:0] boot_port_sel;
    logic               cache_init_busy;
    logic               cache_init_done;
  } boot_status_s;

endpackage : boot_pkg

// ==== verilog/reset_phase_sampler.sv ====
// samples the reset level on the input clock and reports release and a half-rate phase strobe
module reset_phase_sampler (
  input  wire logic clock,
  input  wire logic rst,
  output logic      released,
  output logic      phase
);

  typedef struct packed {
    logic hold;
    logic rel;
    logic ph;
  } samp_s;

  samp_s state_reg;
  samp_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.ph   = ~state_reg.ph;
    state_next.hold = 1'b1;
    state_next.rel  = state_reg.hold;
  end

  // asserted asynchronously; release seen on the first edge with reset low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign released = state_reg.hold;
  assign phase    = state_reg.ph;

endmodule : reset_phase_sampler

// ==== verilog/reset_release_and_boot_start.sv ====
// reset release sequencing: strap capture, boot fetch start and cache init
// Overview of operation
// - On reset release the device starts fetching boot code from the configured port.
// - On reset release the device runs a cache initialisation lasting 1028 input clocks.
// - During reset the four configuration strap pins are left undriven.
// - The strap levels at reset removal are latched as the start-up configuration.
// - Straps are captured on the second rising edge with reset sampled low.
// - Reset is sampled with the input clock; the sampler's phase strobe toggles at half the input rate and is unused.
module reset_release_and_boot_start #(
  parameter int unsigned CACHE_CYCLES = boot_pkg::CACHE_INIT_CYC
) (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic [boot_pkg::STRAP_W-1:0] config_strap_pins_in,
  output logic [boot_pkg::STRAP_W-1:0]      config_strap_pins_out,
  output logic [boot_pkg::STRAP_W-1:0]      config_strap_pins_oe,
  output logic [boot_pkg::STRAP_W-1:0]      config_value,
  output logic                              boot_fetch_start,
  output logic                              boot_fetch_active,
  output logic                              cache_init_busy,
  output logic                              cache_init_done
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    boot_pkg::boot_state_e       st;
    logic [boot_pkg::STRAP_W-1:0] cfg;
    logic [boot_pkg::CNT_W-1:0]   cnt;
    boot_pkg::boot_status_s       stat;
    boot_pkg::strap_drive_s       drv;
  } top_s;

  top_s state_reg;
  top_s state_next;
  logic released;

  // ----------------------------------------------------------------
  // reset sampling
  // ----------------------------------------------------------------
  // reset sampling
  // the phase strobe is not used by the sampler or by this block, so it is left open here
  reset_phase_sampler u_sampler (
    .clock    (clock),
    .rst      (rst),
    .released (released),
    .phase    ()
  );

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  // the count starts at zero, so the last value is one below the length
  localparam logic [boot_pkg::CNT_W-1:0] CACHE_LAST =
    boot_pkg::CNT_W'(CACHE_CYCLES - 1);
  localparam logic [boot_pkg::CNT_W-1:0] CNT_FIRST = '0;
  localparam logic [boot_pkg::CNT_W-1:0] CNT_STEP  = boot_pkg::CNT_W'(1);

  localparam boot_pkg::boot_status_s STATUS_CLEAR = '{
    boot_fetch_start  : 1'b0,
    boot_fetch_active : 1'b0,
    boot_port_sel     : boot_pkg::STRAP_RESET,
    cache_init_busy   : 1'b0,
    cache_init_done   : 1'b0
  };

  // strap pins are never driven from this side
  localparam boot_pkg::strap_drive_s DRIVE_OFF = '{
    out : '0,
    oe  : '0
  };

  localparam top_s RESET_STATE = '{
    st   : boot_pkg::ST_IDLE,
    cfg  : boot_pkg::STRAP_RESET,
    cnt  : CNT_FIRST,
    stat : STATUS_CLEAR,
    drv  : DRIVE_OFF
  };

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic count_at_last(
    input logic [boot_pkg::CNT_W-1:0] cnt
  );
    return cnt == CACHE_LAST;
  endfunction : count_at_last

  function automatic logic [boot_pkg::CNT_W-1:0] count_step(
    input logic [boot_pkg::CNT_W-1:0] cnt
  );
    return cnt + CNT_STEP;
  endfunction : count_step

  // fetch from the strap selected port
  function automatic boot_pkg::boot_status_s status_at_release(
    input logic [boot_pkg::STRAP_W-1:0] straps
  );
    boot_pkg::boot_status_s s;
    s                   = STATUS_CLEAR;
    s.boot_fetch_start  = 1'b1;
    s.boot_fetch_active = 1'b1;
    s.boot_port_sel     = straps;
    s.cache_init_busy   = 1'b1;
    return s;
  endfunction : status_at_release

  // fixed length count
  // one step of the cache initialisation; done stays set until reset
  function automatic top_s cache_step(
    input top_s cur
  );
    top_s nxt;
    nxt = cur;
    if (cur.stat.cache_init_busy) begin
      if (count_at_last(cur.cnt)) begin
        nxt.stat.cache_init_busy = 1'b0;
        nxt.stat.cache_init_done = 1'b1;
      end else begin
        nxt.cnt = count_step(cur.cnt);
      end
    end
    return nxt;
  endfunction : cache_step

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next     = state_reg;
    state_next.drv = DRIVE_OFF;
    // the start strobe stands for one cycle only
    state_next.stat.boot_fetch_start = 1'b0;
    case (state_reg.st)
      boot_pkg::ST_IDLE: begin
        // second edge with reset low
        // the sampler reports release one edge late, so this is the second edge with reset low
        if (released) begin
          state_next.cfg = config_strap_pins_in;
          state_next.stat = status_at_release(config_strap_pins_in);
          state_next.cnt  = CNT_FIRST;
          state_next.st   = boot_pkg::ST_RUN;
        end
      end
      boot_pkg::ST_RUN: begin
        state_next     = cache_step(state_reg);
        state_next.drv = DRIVE_OFF;
        state_next.stat.boot_fetch_start = 1'b0;
      end
      default: begin
        // an upset state keeps the captured value rather than refetching
        state_next.st = boot_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // strap pins
  // ----------------------------------------------------------------
  // straps are inputs only in this block; the drive stays off after release too
  assign config_strap_pins_out = state_reg.drv.out;
  assign config_strap_pins_oe  = state_reg.drv.oe;

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  assign config_value          = state_reg.cfg;

  // ----------------------------------------------------------------
  // boot fetch
  // ----------------------------------------------------------------
  assign boot_fetch_start      = state_reg.stat.boot_fetch_start;
  assign boot_fetch_active     = state_reg.stat.boot_fetch_active;

  // ----------------------------------------------------------------
  // cache initialisation
  // ----------------------------------------------------------------
  assign cache_init_busy       = state_reg.stat.cache_init_busy;
  assign cache_init_done       = state_reg.stat.cache_init_done;

endmodule : reset_release_and_boot_start

// ==== tb/reset_release_and_boot_start_sva.sv ====
// assertions on the reset release sequence
module reset_release_and_boot_start_sva #(
  parameter int unsigned CACHE_CYCLES = boot_pkg::CACHE_INIT_CYC
) (
  input wire logic                         clock,
  input wire logic                         rst,
  input wire logic [boot_pkg::STRAP_W-1:0] config_strap_pins_in,
  input wire logic [boot_pkg::STRAP_W-1:0] config_strap_pins_oe,
  input wire logic [boot_pkg::STRAP_W-1:0] config_value,
  input wire logic                         boot_fetch_start,
  input wire logic                         boot_fetch_active,
  input wire logic                         cache_init_busy,
  input wire logic                         cache_init_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0] busy_cnt;
  // counts busy cycles, cleared only by reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) busy_cnt <= 16'h0;
    else if (cache_init_busy) busy_cnt <= busy_cnt + 16'h1;
  end
  sequence s_rel; $fell(rst); endsequence
  sequence s_go; boot_fetch_start && cache_init_busy ##1 !boot_fetch_start; endsequence
  property p_start; s_rel |-> ##2 s_go; endproperty
  a_start: assert property (p_start) else $error("start late");
  property p_cap; s_rel |-> ##2 config_value == $past(config_strap_pins_in); endproperty
  a_cap: assert property (p_cap) else $error("bad capture");
  property p_hold; boot_fetch_active |=> $stable(config_value); endproperty
  a_hold: assert property (p_hold) else $error("config moved");
  property p_len; $fell(cache_init_busy) |-> cache_init_done && busy_cnt == CACHE_CYCLES; endproperty
  a_len: assert property (p_len) else $error("bad init length");
  property p_oe; disable iff (1'b0) config_strap_pins_oe == 4'h0; endproperty
  a_oe: assert property (p_oe) else $error("strap driven");
  property p_quiet; disable iff (1'b0) rst |-> !boot_fetch_active && config_value == 4'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("active in reset");
  property p_one; boot_fetch_start |=> !boot_fetch_start [*8]; endproperty
  a_one: assert property (p_one) else $error("second start");
  property p_done; cache_init_done |-> boot_fetch_active && !cache_init_busy; endproperty
  a_done: assert property (p_done) else $error("done with busy");
endmodule : reset_release_and_boot_start_sva

// ==== tb/board_reset_model.sv ====
// board reset controller and strap driver
module board_reset_model (
  input  wire logic                    clock,
  output logic                         rst,
  output logic [boot_pkg::STRAP_W-1:0] straps
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rst = 1'b1;
  initial straps = 4'h0;
  task automatic run(input logic [3:0] v, input int hold);
    @(posedge clock);
    rst    <= 1'b1;
    straps <= v;
    repeat (hold) @(posedge clock);
    rst <= 1'b0;
    // straps only change after the hold edge, to prove they are ignored
    repeat (3) @(posedge clock);
    straps <= ~v;
  endtask : run
endmodule : board_reset_model

// ==== tb/reset_release_and_boot_start_tb_top.sv ====
// self-checking bench for reset release and boot start
module reset_release_and_boot_start_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t mismatch", $time); end end
  logic       clock = 1'b0;
  logic       rst, fs, fa, busy, done;
  logic [3:0] straps, cv, pout, poe;
  logic [3:0] notes[$];
  int         n_errors = 0;
  int         total_checks = 0;
  initial forever #5 clock = ~clock;
  board_reset_model i_board_reset_model (.clock(clock), .rst(rst), .straps(straps));
  reset_release_and_boot_start i_reset_release_and_boot_start (.clock(clock), .rst(rst),
    .config_strap_pins_in(straps), .config_strap_pins_out(pout), .config_strap_pins_oe(poe),
    .config_value(cv), .boot_fetch_start(fs), .boot_fetch_active(fa),
    .cache_init_busy(busy), .cache_init_done(done));
  always @(negedge clock) if (fs === 1'b1) begin
    `CHK(cv, notes.pop_front())
    `CHK(busy, 1'b1)
  end
  task automatic seq(input int hold, input int len);
    logic [3:0] v;
    v = 4'($urandom());
    notes.push_back(v);
    fork
      i_board_reset_model.run(v, hold);
      begin
        #20;
        `CHK({poe, pout, fa, busy}, 10'h0)
      end
    join
    repeat (len) @(posedge clock);
    #1;
    if (len > 1030) begin
      `CHK({cv, fa, busy, done}, {v, 3'h5})
    end else begin
      `CHK({cv, fa, busy, done}, {v, 3'h6})
    end
    `CHK(poe, 4'h0)
  endtask : seq
  task automatic summarize();
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(32'h42033668));
    seq(10000, 1100);
    seq(10000, 500);
    seq(10200, 1100);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    summarize();
  end
endmodule : reset_release_and_boot_start_tb_top
bind reset_release_and_boot_start reset_release_and_boot_start_sva #(
  .CACHE_CYCLES(CACHE_CYCLES)) i_reset_release_and_boot_start_sva (.clock(clock), .rst(rst),
  .config_strap_pins_in(config_strap_pins_in), .config_strap_pins_oe(config_strap_pins_oe),
  .config_value(config_value), .boot_fetch_start(boot_fetch_start),
  .boot_fetch_active(boot_fetch_active), .cache_init_busy(cache_init_busy),
  .cache_init_done(cache_init_done));
